// ### hdl/gmf_framer.sv
// gmf_framer: serialises confirmation and indication messages as 16-bit words
// assumes the host pulls words with a ready signal; events come from local logic
`timescale 1ns/1ps
module gmf_framer (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire gmf_pkg::gmf_req_t req_in,
  input wire gmf_pkg::gmf_item_t [gmf_pkg::MAX_ITEMS-1:0] items_in,
  input wire logic err_valid_in,
  input wire logic [15:0] err_code_in,
  output logic word_valid_out,
  input wire logic word_ready_in,
  output gmf_pkg::gmf_word_t word_out,
  output logic ctrl_err_out,
  output logic [15:0] diag_code_out,
  output logic [7:0] diag_count_out
);
  typedef enum logic [1:0] {GMF_IDLE, GMF_SEND} gmf_state_t;

  logic rst_meta_ff;
  logic rst_sync_ff;
  gmf_state_t state_ff;
  gmf_state_t nxt_state;
  gmf_pkg::gmf_req_t req_ff;
  gmf_pkg::gmf_item_t [gmf_pkg::MAX_ITEMS-1:0] items_ff;
  logic [4:0] pos_ff;
  logic [4:0] nxt_pos;
  gmf_pkg::gmf_word_t out_ff;
  logic valid_ff;
  logic ctrl_err_ff;
  logic [15:0] diag_code_ff;
  logic [7:0] diag_count_ff;
  wire [15:0] sel_word;
  wire [15:0] sel_count;
  wire [15:0] last_pos;
  wire take_req;
  wire word_taken;
  wire load_next;
  wire is_last;
  wire is_recovery;
  gmf_pkg::gmf_req_t clean_req;

  // reset release through two flops
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  gmf_word_sel u_sel (
    .req_in(req_ff),
    .items_in(items_ff),
    .pos_in(pos_ff),
    .word_out(sel_word),
    .count_out(sel_count)
  );

  // no request accepted while the internal reset still holds
  assign req_ready_out = rst_sync_ff && (state_ff == GMF_IDLE) && !valid_ff;
  assign take_req = req_valid_in && req_ready_out;
  assign word_taken = valid_ff && word_ready_in;
  assign last_pos = 16'(sel_count + 16'h0001);
  assign is_last = ({11'h000, pos_ff} == last_pos);
  assign load_next = (state_ff == GMF_SEND) && (!valid_ff || word_taken);
  assign word_valid_out = valid_ff;
  assign word_out = out_ff;
  assign is_recovery = err_valid_in &&
                       ((err_code_in == gmf_pkg::ERR_BUS_SYSTEM) ||
                        (err_code_in == gmf_pkg::ERR_FIFO_OVF));
  assign ctrl_err_out = ctrl_err_ff;
  assign diag_code_out = diag_code_ff;
  assign diag_count_out = diag_count_ff;

  // out-of-range error numbers collapse to the id-cycle failure
  always_comb begin
    clean_req = req_in;
    if (req_in.err_num > gmf_pkg::ERRNUM_MAX || req_in.err_num < gmf_pkg::ERRNUM_MIN) begin
      clean_req.err_num = gmf_pkg::ERRNUM_ID_CYCLE[2:0];
    end
    // item list cannot exceed storage
    if (req_in.n_items > 4'(gmf_pkg::MAX_ITEMS)) begin
      clean_req.n_items = 4'(gmf_pkg::MAX_ITEMS);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    unique case (state_ff)
      GMF_IDLE: begin
        if (take_req) begin
          nxt_state = GMF_SEND;
          nxt_pos = 5'h0;
        end
      end
      GMF_SEND: begin
        if (load_next) begin
          nxt_pos = 5'(pos_ff + 5'h1);
          if (is_last) begin
            nxt_state = GMF_IDLE;
          end
        end
      end
      default: nxt_state = GMF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= GMF_IDLE;
      pos_ff <= 5'h0;
      req_ff <= '0;
      items_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      if (take_req) begin
        req_ff <= clean_req;
        items_ff <= items_in;
      end
    end
  end

  // output word register: code, count, then the counted parameters
  always_ff @(posedge sys_clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      out_ff <= '0;
      valid_ff <= 1'b0;
    end else if (load_next) begin
      out_ff.data <= sel_word;
      out_ff.first <= (pos_ff == 5'h0);
      out_ff.last <= is_last;
      valid_ff <= 1'b1;
    end else if (word_taken) begin
      valid_ff <= 1'b0;
    end
  end

  // controller error flag and diagnostic log of recovery codes
  always_ff @(posedge sys_clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_err_ff <= 1'b0;
      diag_code_ff <= 16'h0000;
      diag_count_ff <= 8'h00;
    end else if (is_recovery) begin
      ctrl_err_ff <= 1'b1;
      diag_code_ff <= err_code_in;
      if (diag_count_ff != 8'hFF) begin
        diag_count_ff <= 8'(diag_count_ff + 8'h01);
      end
    end
  end

  // message framing checks and recovery logging check
  a_code_first: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (word_valid_out && word_out.first) |-> (pos_ff == 5'h1))
    else $error("code word not at message start");
  a_count_word: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (load_next && pos_ff == 5'h1) |=> (word_out.data == $past(sel_count)))
    else $error("count word wrong");
  a_reconfig_code: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (load_next && pos_ff == 5'h0 && req_ff.kind == gmf_pkg::GMF_MSG_RECONFIG)
      |=> (word_out.data == gmf_pkg::CODE_RECONFIG))
    else $error("reconfig code wrong");
  a_reconfig_len: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (state_ff == GMF_SEND && req_ff.kind == gmf_pkg::GMF_MSG_RECONFIG)
      |-> (sel_count == gmf_pkg::CNT_RECONFIG))
    else $error("reconfig count wrong");
  a_group_range: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (word_valid_out && !word_out.first && req_ff.kind == gmf_pkg::GMF_MSG_RECONFIG
      && pos_ff > 5'h2) |-> (word_out.data[15:8] == 8'h00))
    else $error("address or group out of range");
  a_fail_count: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (state_ff == GMF_SEND && req_ff.fail && (req_ff.kind == gmf_pkg::GMF_MSG_GROUP_NUM ||
     req_ff.kind == gmf_pkg::GMF_MSG_GROUP_STAT || req_ff.kind == gmf_pkg::GMF_MSG_LB_MAP))
      |-> (sel_count == gmf_pkg::CNT_FAIL))
    else $error("failure count not three");
  a_result_ok: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (load_next && pos_ff == 5'h2 && !req_ff.fail &&
     (req_ff.kind == gmf_pkg::GMF_MSG_GROUP_NUM || req_ff.kind == gmf_pkg::GMF_MSG_GROUP_STAT ||
      req_ff.kind == gmf_pkg::GMF_MSG_LB_MAP))
      |=> (word_out.data[15:8] == gmf_pkg::RESULT_OK))
    else $error("positive result word wrong");
  a_state_word: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (load_next && pos_ff > 5'h2 && !req_ff.fail && req_ff.kind == gmf_pkg::GMF_MSG_GROUP_STAT)
      |=> (word_out.data[7:1] == 7'h00))
    else $error("state word spare bits not zero");
  a_quit_all: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (load_next && pos_ff == 5'h2 && req_ff.kind == gmf_pkg::GMF_MSG_PARAM_ERR &&
     req_ff.req_code == gmf_pkg::REQ_QUIT_ALL)
      |=> (word_out.data == gmf_pkg::ERRNUM_ID_CYCLE))
    else $error("quit-all error number not five");
  a_recovery_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    is_recovery |=> (ctrl_err_out && diag_code_out == $past(err_code_in)))
    else $error("recovery code not logged");
  a_pwr_len: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_ff)
    (state_ff == GMF_SEND && req_ff.kind == gmf_pkg::GMF_MSG_PWR_FAIL)
      |-> (sel_count == gmf_pkg::CNT_ONE))
    else $error("power fail count not one");
endmodule

// ### hdl/gmf_pkg.sv
// gmf_pkg: shared codes, field positions and carrier types of the group message framer
// assumes one 125 MHz clock domain; no software-visible registers
package gmf_pkg;
  localparam int WORD_W = 16;
  localparam int MAX_ITEMS = 8;
  localparam int IDX_W = 4;
  // message codes
  localparam logic [15:0] CODE_RECONFIG = 16'h8106;
  localparam logic [15:0] CODE_GROUP_NUM = 16'h8112;
  localparam logic [15:0] CODE_GROUP_STAT = 16'h8113;
  localparam logic [15:0] CODE_LB_MAP = 16'h8114;
  localparam logic [15:0] CODE_MOD_ERR = 16'h80A0;
  localparam logic [15:0] CODE_PWR_FAIL = 16'h80A1;
  localparam logic [15:0] CODE_ACK_SET_LOG = 16'h00CB;
  localparam logic [15:0] CODE_ACK_RST_LOG = 16'h00CC;
  localparam logic [15:0] CODE_ACK_RST_PHY = 16'h00CE;
  localparam logic [15:0] CODE_PARAM_ERR = 16'h503B;
  // request codes being acknowledged
  localparam logic [15:0] REQ_SET_LOG = 16'h0024;
  localparam logic [15:0] REQ_RST_LOG = 16'h0025;
  localparam logic [15:0] REQ_RST_PHY = 16'h0027;
  localparam logic [15:0] REQ_QUIT_ALL = 16'h0065;
  // error recovery codes shown as controller error
  localparam logic [15:0] ERR_BUS_SYSTEM = 16'h0038;
  localparam logic [15:0] ERR_FIFO_OVF = 16'h003C;
  // result word prefixes and counts
  localparam logic [7:0] RESULT_OK = 8'h00;
  localparam logic [7:0] RESULT_FAIL = 8'hFF;
  localparam logic [15:0] CNT_RECONFIG = 16'h0002;
  localparam logic [15:0] CNT_FAIL = 16'h0003;
  localparam logic [15:0] CNT_PARAM_ERR = 16'h0002;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] ERRNUM_ID_CYCLE = 16'h0005;
  localparam logic [2:0] ERRNUM_MAX = 3'h5;
  localparam logic [2:0] ERRNUM_MIN = 3'h1;
  // field positions
  localparam int STATE_BIT = 0;
  localparam int GRP_LSB = 8;
  localparam int LBNUM_W = 12;
  localparam int DEPTH_LSB = 12;
  localparam int DIAG_W = 16;

  typedef enum logic [3:0] {
    GMF_MSG_RECONFIG,
    GMF_MSG_GROUP_NUM,
    GMF_MSG_GROUP_STAT,
    GMF_MSG_LB_MAP,
    GMF_MSG_MOD_ERR,
    GMF_MSG_PWR_FAIL,
    GMF_MSG_ACK_SET_LOG,
    GMF_MSG_ACK_RST_LOG,
    GMF_MSG_ACK_RST_PHY,
    GMF_MSG_PARAM_ERR
  } gmf_kind_t;

  // one list entry; meaning depends on message kind
  typedef struct packed {
    logic [7:0] lb_addr;
    logic [7:0] group;
    logic group_on;
    logic [11:0] lb_num;
    logic [3:0] depth;
  } gmf_item_t;

  typedef struct packed {
    gmf_kind_t kind;
    logic fail;
    logic [7:0] result_lo;
    logic [15:0] err_word;
    logic [15:0] add_word;
    logic [2:0] err_num;
    logic [15:0] param_num;
    logic [15:0] req_code;
    logic [IDX_W-1:0] n_items;
  } gmf_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic first;
    logic last;
  } gmf_word_t;
endpackage

// ### hdl/gmf_word_sel.sv
// gmf_word_sel: picks the word at a position of a message being framed
// assumes request and item list held stable by the framer while it runs
`timescale 1ns/1ps
module gmf_word_sel (
  input wire gmf_pkg::gmf_req_t req_in,
  input wire gmf_pkg::gmf_item_t [gmf_pkg::MAX_ITEMS-1:0] items_in,
  input wire logic [4:0] pos_in,
  output logic [15:0] word_out,
  output logic [15:0] count_out
);
  wire gmf_pkg::gmf_item_t pair_item;
  wire gmf_pkg::gmf_item_t one_item;
  wire [15:0] lb_word;
  wire [15:0] grp_word;
  wire [15:0] stat_word;
  wire [15:0] map_word;
  wire [15:0] result_word;
  logic [15:0] code_word;
  wire [15:0] err_num_word;
  wire [4:0] pair_idx;
  wire [4:0] one_idx;
  wire [15:0] n16;

  assign n16 = {12'h000, req_in.n_items};
  assign pair_idx = 5'((pos_in - 5'h3) >> 1);
  assign one_idx = pos_in - 5'h3;
  assign pair_item = items_in[pair_idx[2:0]];
  assign one_item = items_in[one_idx[2:0]];
  // addresses and groups are 8-bit fields, so 0..255 by construction
  assign lb_word = {8'h00, pair_item.lb_addr};
  assign grp_word = {8'h00, pair_item.group};
  assign stat_word = {one_item.group, 7'h00, one_item.group_on};
  assign map_word = {one_item.depth, one_item.lb_num};
  assign result_word = {req_in.fail ? gmf_pkg::RESULT_FAIL : gmf_pkg::RESULT_OK,
                        req_in.result_lo};
  // quit-all only ever reports the id-cycle failure
  assign err_num_word = (req_in.req_code == gmf_pkg::REQ_QUIT_ALL) ?
                        gmf_pkg::ERRNUM_ID_CYCLE : {13'h0000, req_in.err_num};

  always_comb begin
    unique case (req_in.kind)
      gmf_pkg::GMF_MSG_RECONFIG: code_word = gmf_pkg::CODE_RECONFIG;
      gmf_pkg::GMF_MSG_GROUP_NUM: code_word = gmf_pkg::CODE_GROUP_NUM;
      gmf_pkg::GMF_MSG_GROUP_STAT: code_word = gmf_pkg::CODE_GROUP_STAT;
      gmf_pkg::GMF_MSG_LB_MAP: code_word = gmf_pkg::CODE_LB_MAP;
      gmf_pkg::GMF_MSG_MOD_ERR: code_word = gmf_pkg::CODE_MOD_ERR;
      gmf_pkg::GMF_MSG_PWR_FAIL: code_word = gmf_pkg::CODE_PWR_FAIL;
      gmf_pkg::GMF_MSG_ACK_SET_LOG: code_word = gmf_pkg::CODE_ACK_SET_LOG;
      gmf_pkg::GMF_MSG_ACK_RST_LOG: code_word = gmf_pkg::CODE_ACK_RST_LOG;
      gmf_pkg::GMF_MSG_ACK_RST_PHY: code_word = gmf_pkg::CODE_ACK_RST_PHY;
      default: code_word = gmf_pkg::CODE_PARAM_ERR;
    endcase
  end

  always_comb begin
    count_out = gmf_pkg::CNT_ZERO;
    unique case (req_in.kind)
      gmf_pkg::GMF_MSG_RECONFIG: count_out = gmf_pkg::CNT_RECONFIG;
      gmf_pkg::GMF_MSG_GROUP_NUM:
        count_out = req_in.fail ? gmf_pkg::CNT_FAIL : 16'((n16 << 1) + 16'h0001);
      gmf_pkg::GMF_MSG_GROUP_STAT, gmf_pkg::GMF_MSG_LB_MAP:
        count_out = req_in.fail ? gmf_pkg::CNT_FAIL : 16'(n16 + 16'h0001);
      gmf_pkg::GMF_MSG_MOD_ERR: count_out = n16;
      gmf_pkg::GMF_MSG_PWR_FAIL: count_out = gmf_pkg::CNT_ONE;
      gmf_pkg::GMF_MSG_PARAM_ERR: count_out = gmf_pkg::CNT_PARAM_ERR;
      default: count_out = gmf_pkg::CNT_ZERO;
    endcase
  end

  // pos 0 code, 1 count, 2.. parameters
  always_comb begin
    word_out = 16'h0000;
    if (pos_in == 5'h0) begin
      word_out = code_word;
    end else if (pos_in == 5'h1) begin
      word_out = count_out;
    end else begin
      unique case (req_in.kind)
        gmf_pkg::GMF_MSG_RECONFIG:
          word_out = (pos_in == 5'h2) ? {8'h00, req_in.add_word[15:8]}
                                      : {8'h00, req_in.add_word[7:0]};
        gmf_pkg::GMF_MSG_GROUP_NUM, gmf_pkg::GMF_MSG_GROUP_STAT,
        gmf_pkg::GMF_MSG_LB_MAP: begin
          if (pos_in == 5'h2) begin
            word_out = result_word;
          end else if (req_in.fail) begin
            word_out = (pos_in == 5'h3) ? req_in.err_word : req_in.add_word;
          end else if (req_in.kind == gmf_pkg::GMF_MSG_GROUP_NUM) begin
            word_out = pos_in[0] ? lb_word : grp_word;
          end else if (req_in.kind == gmf_pkg::GMF_MSG_GROUP_STAT) begin
            word_out = stat_word;
          end else begin
            word_out = map_word;
          end
        end
        gmf_pkg::GMF_MSG_MOD_ERR:
          word_out = {8'h00, items_in[3'(pos_in - 5'h2)].lb_addr};
        gmf_pkg::GMF_MSG_PWR_FAIL: word_out = {8'h00, req_in.add_word[7:0]};
        gmf_pkg::GMF_MSG_PARAM_ERR:
          word_out = (pos_in == 5'h2) ? err_num_word : req_in.param_num;
        default: word_out = 16'h0000;
      endcase
    end
  end
endmodule

// ### verification/gmf_framer_bench.sv
// gmf_framer_bench: self-checking bench of the group message framer
// assumes a 125 MHz clock, host model on the word port, bench drives requests
`timescale 1ns/1ps
module gmf_framer_bench;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_ready_out;
  gmf_pkg::gmf_req_t req_in = '0;
  gmf_pkg::gmf_item_t [gmf_pkg::MAX_ITEMS-1:0] items_in = '0;
  logic err_valid_in = 1'b0;
  logic [15:0] err_code_in = 16'h0000;
  logic word_valid_out;
  logic word_ready_in;
  logic ctrl_err_out;
  gmf_pkg::gmf_word_t word_out;
  logic [15:0] diag_code_out;
  logic [7:0] diag_count_out;
  logic slow = 1'b0;
  logic [7:0] proto_err;
  logic [15:0] ew[$];
  int error_cnt = 0;
  int total_checks = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  gmf_framer DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .items_in(items_in),
    .err_valid_in(err_valid_in), .err_code_in(err_code_in), .word_valid_out(word_valid_out),
    .word_ready_in(word_ready_in), .word_out(word_out), .ctrl_err_out(ctrl_err_out),
    .diag_code_out(diag_code_out), .diag_count_out(diag_count_out));
  gmf_host_model host (.clk_in(sys_clk_in), .resetn_in(resetn_in), .slow_in(slow),
    .word_valid_in(word_valid_out), .word_in(word_out), .word_ready_out(word_ready_in),
    .proto_err_out(proto_err));
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic set_req(input gmf_pkg::gmf_kind_t k, input logic f, input logic [3:0] n);
    req_in = '0;
    req_in.kind = k;
    req_in.fail = f;
    req_in.result_lo = 8'hA5;
    req_in.err_word = 16'hE123;
    req_in.add_word = 16'hC0DE;
    req_in.n_items = n;
    for (int i = 0; i < 8; i++) begin
      items_in[i].lb_addr = 8'hF8 - 8'(i);
      items_in[i].group = 8'h81 + 8'(i * 17);
      items_in[i].group_on = i[0];
      items_in[i].lb_num = 12'hFF0 + 12'(i);
      items_in[i].depth = 4'(i % 2);
    end
  endtask
  // one request, then the whole message compared word by word with flags
  task automatic run_msg(input string what);
    int n;
    logic [17:0] got;
    n = 0;
    @(negedge sys_clk_in);
    while (req_ready_out !== 1'b1 && n < 100) begin
      @(negedge sys_clk_in);
      n++;
    end
    req_valid_in = 1'b1;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    check({what, " busy"}, 18'(req_ready_out), 18'h0);
    n = 0;
    while (host.rx_q.size() < ew.size() && n < 200) begin
      @(negedge sys_clk_in);
      n++;
    end
    repeat (4) @(negedge sys_clk_in);
    check({what, " length"}, 18'(host.rx_q.size()), 18'(ew.size()));
    for (int i = 0; i < ew.size(); i++) begin
      got = (i < host.rx_q.size()) ? host.rx_q[i] : 18'h00000;
      check(what, got, {ew[i], i == 0, i == ew.size() - 1});
    end
    host.rx_q.delete();
    ew.delete();
  endtask
  task automatic t_reset();
    check("ctrl err reset", 18'(ctrl_err_out), 18'h0);
    check("diag count reset", 18'(diag_count_out), 18'h0);
    check("diag code reset", 18'(diag_code_out), 18'h0);
    check("word valid reset", 18'(word_valid_out), 18'h0);
    check("req ready reset", 18'(req_ready_out), 18'h0);
  endtask
  task automatic t_reconfig();
    set_req(gmf_pkg::GMF_MSG_RECONFIG, 1'b0, 4'h0);
    ew = {gmf_pkg::CODE_RECONFIG, gmf_pkg::CNT_RECONFIG, 16'h00C0, 16'h00DE};
    run_msg("reconfig");
  endtask
  task automatic t_group_num();
    for (int k = 0; k <= 8; k += 8) begin
      set_req(gmf_pkg::GMF_MSG_GROUP_NUM, 1'b0, 4'(k));
      ew = {gmf_pkg::CODE_GROUP_NUM, 16'(2 * k + 1), 16'h00A5};
      for (int i = 0; i < k; i++) ew = {ew, 16'(items_in[i].lb_addr), 16'(items_in[i].group)};
      slow = (k == 8);
      run_msg("group num");
    end
    slow = 1'b0;
  endtask
  task automatic t_fail();
    gmf_pkg::gmf_kind_t kk[3];
    logic [15:0] cc[3];
    kk = '{gmf_pkg::GMF_MSG_GROUP_NUM, gmf_pkg::GMF_MSG_GROUP_STAT, gmf_pkg::GMF_MSG_LB_MAP};
    cc = '{gmf_pkg::CODE_GROUP_NUM, gmf_pkg::CODE_GROUP_STAT, gmf_pkg::CODE_LB_MAP};
    for (int k = 0; k < 3; k++) begin
      set_req(kk[k], 1'b1, 4'h4);
      ew = {cc[k], gmf_pkg::CNT_FAIL, 16'hFFA5, 16'hE123, 16'hC0DE};
      run_msg("report fail");
    end
  endtask
  task automatic t_lists();
    int m;
    set_req(gmf_pkg::GMF_MSG_GROUP_STAT, 1'b0, 4'h3);
    ew = {gmf_pkg::CODE_GROUP_STAT, 16'h0004, 16'h00A5};
    for (int i = 0; i < 3; i++) ew.push_back({items_in[i].group, 7'h00, items_in[i].group_on});
    run_msg("group status");
    set_req(gmf_pkg::GMF_MSG_LB_MAP, 1'b0, 4'h8);
    ew = {gmf_pkg::CODE_LB_MAP, 16'h0009, 16'h00A5};
    for (int i = 0; i < 8; i++) ew.push_back({items_in[i].depth, items_in[i].lb_num});
    run_msg("bus code map");
    // second pass asks for 12 addresses, clipped to the 8 held
    for (int n = 4; n <= 12; n += 8) begin
      m = (n > gmf_pkg::MAX_ITEMS) ? gmf_pkg::MAX_ITEMS : n;
      set_req(gmf_pkg::GMF_MSG_MOD_ERR, 1'b0, 4'(n));
      ew = {gmf_pkg::CODE_MOD_ERR, 16'(m)};
      for (int i = 0; i < m; i++) ew.push_back(16'(items_in[i].lb_addr));
      run_msg("module error");
    end
    set_req(gmf_pkg::GMF_MSG_PWR_FAIL, 1'b0, 4'h0);
    ew = {gmf_pkg::CODE_PWR_FAIL, gmf_pkg::CNT_ONE, 16'h00DE};
    run_msg("power fail");
  endtask
  task automatic t_acks();
    gmf_pkg::gmf_kind_t kk[3];
    logic [15:0] cc[3];
    logic [15:0] rq[3];
    kk = '{gmf_pkg::GMF_MSG_ACK_SET_LOG, gmf_pkg::GMF_MSG_ACK_RST_LOG,
      gmf_pkg::GMF_MSG_ACK_RST_PHY};
    cc = '{gmf_pkg::CODE_ACK_SET_LOG, gmf_pkg::CODE_ACK_RST_LOG, gmf_pkg::CODE_ACK_RST_PHY};
    rq = '{gmf_pkg::REQ_SET_LOG, gmf_pkg::REQ_RST_LOG, gmf_pkg::REQ_RST_PHY};
    for (int k = 0; k < 3; k++) begin
      set_req(kk[k], 1'b0, 4'h0);
      req_in.req_code = rq[k];
      ew = {cc[k], gmf_pkg::CNT_ZERO};
      run_msg("alarm ack");
    end
  endtask
  task automatic t_param_err();
    logic [2:0] e;
    for (int k = 0; k < 9; k++) begin
      set_req(gmf_pkg::GMF_MSG_PARAM_ERR, 1'b0, 4'h0);
      req_in.err_num = (k == 8) ? 3'h2 : 3'(k);
      req_in.param_num = 16'h0100 + 16'(k);
      req_in.req_code = (k == 8) ? gmf_pkg::REQ_QUIT_ALL : 16'h0000;
      e = (k >= 1 && k <= 5) ? 3'(k) : 3'h5;
      ew = {gmf_pkg::CODE_PARAM_ERR, gmf_pkg::CNT_PARAM_ERR, 16'(e), req_in.param_num};
      run_msg("param error");
    end
  endtask
  task automatic pulse_err(input logic [15:0] c);
    @(negedge sys_clk_in);
    err_valid_in = 1'b1;
    err_code_in = c;
    @(negedge sys_clk_in);
    err_valid_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask
  task automatic t_recovery();
    pulse_err(16'h0024);
    check("ctrl err ignored", 18'(ctrl_err_out), 18'h0);
    check("diag count ignored", 18'(diag_count_out), 18'h0);
    pulse_err(gmf_pkg::ERR_BUS_SYSTEM);
    check("ctrl err", 18'(ctrl_err_out), 18'h1);
    check("diag code", 18'(diag_code_out), 18'h00038);
    check("diag count", 18'(diag_count_out), 18'h1);
    pulse_err(gmf_pkg::ERR_FIFO_OVF);
    check("diag code", 18'(diag_code_out), 18'h0003C);
    check("diag count", 18'(diag_count_out), 18'h2);
    check("ctrl err sticky", 18'(ctrl_err_out), 18'h1);
    @(negedge sys_clk_in);
    resetn_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    t_reset();
    resetn_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
  endtask
  initial begin
    #200000;
    error_cnt++;
    $display("FAIL watchdog expected done seen hang");
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge sys_clk_in);
    t_reset();
    resetn_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check("req ready after reset", 18'(req_ready_out), 18'h1);
    t_reconfig();
    t_group_num();
    t_fail();
    t_lists();
    t_acks();
    t_param_err();
    t_recovery();
    t_reconfig();
    check("host framing", 18'(proto_err), 18'h0);
    tally_and_finish();
  end
endmodule

// ### verification/gmf_host_model.sv
// gmf_host_model: host side that pulls framed message words and keeps them in rx_q
// assumes the framer word port; the bench reads and clears rx_q between messages
`timescale 1ns/1ps
module gmf_host_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic word_valid_in,
  input wire gmf_pkg::gmf_word_t word_in,
  output logic word_ready_out,
  output logic [7:0] proto_err_out
);
  logic [17:0] rx_q[$];
  int pos;
  int remain;
  logic at_end;
  initial begin
    word_ready_out = 1'b0;
    proto_err_out = 8'h00;
    pos = 0;
    remain = 0;
  end
  // slow host only takes every other cycle
  always @(negedge clk_in) begin
    word_ready_out <= resetn_in && (!slow_in || !word_ready_out);
  end
  // code word first, then the count word, then exactly that many words before the next code
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      pos = 0;
    end else if (word_valid_in && word_ready_out) begin
      rx_q.push_back({word_in.data, word_in.first, word_in.last});
      if (pos == 1) remain = int'(word_in.data);
      else if (pos > 1) remain = remain - 1;
      at_end = (pos >= 1) && (remain == 0);
      if (((pos == 0) !== word_in.first) || (at_end !== word_in.last)) begin
        proto_err_out = proto_err_out + 8'h01;
      end
      pos = at_end ? 0 : pos + 1;
    end
  end
endmodule
